// File: tpi_pkg.sv
// Constants shared by the trace port integration-test register block
`default_nettype none
package tpi_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets within the unit's 4 KB window
   // ----------------------------------------------------------------------
   localparam int unsigned ADR_W = 12;
   localparam logic [11:0] OFS_INSTR_DATA = 12'heec;
   localparam logic [11:0] OFS_READY_DRIVE = 12'hef0;
   localparam logic [11:0] OFS_VALID_OBS = 12'hef8;
   localparam logic [11:0] OFS_SW_DATA = 12'hefc;
   localparam logic [11:0] OFS_MODE_CTRL = 12'hf00;
   localparam logic [11:0] OFS_CAP_ID = 12'hfc8;

   // ----------------------------------------------------------------------
   // Integration data register layout
   // ----------------------------------------------------------------------
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned CNT_W = 2;
   localparam int unsigned CAP_DEPTH = 3;
   localparam int unsigned SW_VALID_BIT = 29;
   localparam int unsigned SW_CNT_LSB = 27;
   localparam int unsigned INSTR_VALID_BIT = 26;
   localparam int unsigned INSTR_CNT_LSB = 24;
   localparam int unsigned DATA_LSB = 0;
   localparam int unsigned VALID_OBS_BIT = 0;
   localparam int unsigned READY_DRIVE_BIT = 0;

   // ----------------------------------------------------------------------
   // Mode field encodings and reset values
   // ----------------------------------------------------------------------
   localparam int unsigned MODE_W = 2;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_INTEG = 2'h1;
   localparam logic [1:0] MODE_DATA = 2'h2;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic READY_DRIVE_RST = 1'b0;

   // ----------------------------------------------------------------------
   // Capability register fields
   // ----------------------------------------------------------------------
   localparam int unsigned CAP_NRZ_BIT = 11;
   localparam int unsigned CAP_MANCH_BIT = 10;
   localparam int unsigned CAP_PARALLEL_BIT = 9;
   localparam int unsigned CAP_BUF_LSB = 6;
   localparam logic [2:0] CAP_BUF_4B = 3'h2;
   localparam int unsigned CAP_ASYNC_BIT = 5;
   localparam int unsigned CAP_INPUTS_LSB = 0;
   localparam logic [4:0] CAP_INPUTS_M1 = 5'h01;

endpackage : tpi_pkg
`default_nettype wire

// File: tpi_byte_capture.sv
// Byte capture store for one trace input port in integration data test mode
`timescale 1ns/10ps
`default_nettype none
module tpi_byte_capture
   import tpi_pkg::*;
#(
   parameter int DEPTH = CAP_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic accept_i,
   input wire logic clear_i,
   input wire logic [BYTE_W-1:0] byte_i,
   output logic [CNT_W-1:0] cnt_o,
   output logic [CNT_W-1:0] cnt_nxt_o,
   output logic [CAP_DEPTH*BYTE_W-1:0] data_o
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   if (DEPTH < 1 || DEPTH > int'(CAP_DEPTH)) begin : g_bad_depth
      $error("capture depth must be 1 to 3");
   end

   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] wr_idx;
   logic acc_eff;

   // A read that clears in the same cycle still takes the new byte
   assign acc_eff = accept_i && (clear_i || cnt_r < FULL_CNT);
   assign wr_idx = clear_i ? '0 : cnt_r;

   // Count of bytes held since the last read
   always_comb begin
      if (clear_i) begin
         cnt_nxt_o = acc_eff ? CNT_W'(1) : '0;
      end else if (acc_eff) begin
         cnt_nxt_o = cnt_r + CNT_W'(1);
      end else begin
         cnt_nxt_o = cnt_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt_o;
      end
   end

   assign cnt_o = cnt_r;

   // ----------------------------------------------------------------------
   // Byte slots, byte 0 lowest
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < int'(CAP_DEPTH); i++) begin : g_slot
      logic [BYTE_W-1:0] slot_r;
      if (i < DEPTH) begin : g_used
         // Read discards the held bytes
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               slot_r <= '0;
            end else if (acc_eff && wr_idx == CNT_W'(i)) begin
               slot_r <= byte_i;
            end else if (clear_i) begin
               slot_r <= '0;
            end
         end
      end else begin : g_unused
         assign slot_r = '0;
      end
      assign data_o[i*BYTE_W +: BYTE_W] = slot_r;
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   cnt_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cnt_r <= FULL_CNT)
      else $error("byte count above capture depth");

   clear_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      clear_i && !accept_i |=> cnt_r == '0 && data_o == '0)
      else $error("read did not discard bytes");

endmodule : tpi_byte_capture
`default_nettype wire

// File: tpi_integ_top.sv
// Integration-test and capability registers of the trace port unit
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tpi_integ_top
   import tpi_pkg::*;
#(
   parameter int DEPTH = CAP_DEPTH,
   parameter bit ASYNC_CLKIN = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic port_one_valid_in_i,
   input wire logic [BYTE_W-1:0] port_one_data_i,
   output logic port_one_ready_out_o,
   input wire logic port_two_valid_in_i,
   input wire logic [BYTE_W-1:0] port_two_data_i,
   output logic port_two_ready_out_o,
   input wire logic func_ready_i,
   output logic trace_out_en_o
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   if (DEPTH < 1 || DEPTH > int'(CAP_DEPTH)) begin : g_bad_depth
      $error("capture depth must be 1 to 3");
   end

   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   // Fixed capability word; bit 9 left zero since parallel trace modes are supported
   localparam logic [31:0] CAP_VALUE = (32'h1 << CAP_NRZ_BIT)
      | (32'h1 << CAP_MANCH_BIT)
      | (32'({CAP_BUF_4B}) << CAP_BUF_LSB)
      | (32'({ASYNC_CLKIN}) << CAP_ASYNC_BIT)
      | (32'({CAP_INPUTS_M1}) << CAP_INPUTS_LSB);

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
      return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
   endfunction : hit

   logic ack_r;
   logic [31:0] dat_r;
   logic [MODE_W-1:0] mode_r;
   logic ready_drive_r;
   logic one_ready_r;
   logic two_ready_r;
   logic out_en_r;
   logic req;
   logic rd_take;
   logic wr_take;
   logic rd_instr;
   logic rd_sw;
   logic acc_one;
   logic acc_two;
   logic [CNT_W-1:0] cnt_one;
   logic [CNT_W-1:0] cnt_two;
   logic [CNT_W-1:0] cnt_one_nxt;
   logic [CNT_W-1:0] cnt_two_nxt;
   logic [CAP_DEPTH*BYTE_W-1:0] data_one;
   logic [CAP_DEPTH*BYTE_W-1:0] data_two;
   logic [31:0] rd_word;
   logic [31:0] status_bits;
   logic one_ready_nxt;
   logic two_ready_nxt;

   // One request per ack; the cycle holding ack never starts another
   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   assign rd_take = req && !wb_we_i;
   assign wr_take = req && wb_we_i;
   assign rd_instr = rd_take && hit(wb_adr_i, OFS_INSTR_DATA);
   assign rd_sw = rd_take && hit(wb_adr_i, OFS_SW_DATA);

   // ----------------------------------------------------------------------
   // Wishbone slave: ack one cycle after the request is seen
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   // Read data latched with the side effects, so what is shown is what is discarded
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= '0;
      end else begin
         dat_r <= rd_take ? rd_word : '0;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ----------------------------------------------------------------------
   // Software writable registers
   // ----------------------------------------------------------------------
   // Mode field; 11 is stored but acts as normal mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= MODE_RST;
      end else if (wr_take && wb_sel_i[0] && hit(wb_adr_i, OFS_MODE_CTRL)) begin
         mode_r <= wb_dat_i[MODE_W-1:0];
      end
   end

   // Ready drive bit, only bit 0 is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_drive_r <= READY_DRIVE_RST;
      end else if (wr_take && wb_sel_i[0] && hit(wb_adr_i, OFS_READY_DRIVE)) begin
         ready_drive_r <= wb_dat_i[READY_DRIVE_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Byte capture on each input port
   // ----------------------------------------------------------------------
   // Bytes only taken in data test mode, on a valid/ready handshake
   assign acc_one = mode_r == MODE_DATA && port_one_valid_in_i && one_ready_r;
   assign acc_two = mode_r == MODE_DATA && port_two_valid_in_i && two_ready_r;

   tpi_byte_capture #(
      .DEPTH(DEPTH)
   ) u_cap_one (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .accept_i(acc_one),
      .clear_i(rd_instr),
      .byte_i(port_one_data_i),
      .cnt_o(cnt_one),
      .cnt_nxt_o(cnt_one_nxt),
      .data_o(data_one)
   );

   tpi_byte_capture #(
      .DEPTH(DEPTH)
   ) u_cap_two (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .accept_i(acc_two),
      .clear_i(rd_sw),
      .byte_i(port_two_data_i),
      .cnt_o(cnt_two),
      .cnt_nxt_o(cnt_two_nxt),
      .data_o(data_two)
   );

   // ----------------------------------------------------------------------
   // Ready outputs
   // ----------------------------------------------------------------------
   // Registered so the outputs come from flops; built from next count to avoid overrun
   always_comb begin
      case (mode_r)
         MODE_INTEG: begin
            one_ready_nxt = ready_drive_r;
            two_ready_nxt = ready_drive_r;
         end
         MODE_DATA: begin
            one_ready_nxt = cnt_one_nxt < FULL_CNT;
            two_ready_nxt = cnt_two_nxt < FULL_CNT;
         end
         default: begin
            one_ready_nxt = func_ready_i;
            two_ready_nxt = func_ready_i;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         one_ready_r <= 1'b0;
         two_ready_r <= 1'b0;
      end else begin
         one_ready_r <= one_ready_nxt;
         two_ready_r <= two_ready_nxt;
      end
   end

   // Trace output held off while inputs are diverted to the data registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_en_r <= 1'b0;
      end else begin
         out_en_r <= mode_r != MODE_DATA;
      end
   end

   assign port_one_ready_out_o = one_ready_r;
   assign port_two_ready_out_o = two_ready_r;
   assign trace_out_en_o = out_en_r;

   // ----------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------
   // Status byte shared by both data registers; bits 31:30 stay zero
   always_comb begin
      status_bits = '0;
      status_bits[SW_VALID_BIT] = port_two_valid_in_i;
      status_bits[SW_CNT_LSB +: CNT_W] = cnt_two;
      status_bits[INSTR_VALID_BIT] = port_one_valid_in_i;
      status_bits[INSTR_CNT_LSB +: CNT_W] = cnt_one;
   end

   // Unmapped addresses read zero and still ack
   always_comb begin
      rd_word = '0;
      if (hit(wb_adr_i, OFS_INSTR_DATA)) begin
         rd_word = status_bits | 32'(data_one);
      end else if (hit(wb_adr_i, OFS_SW_DATA)) begin
         rd_word = status_bits | 32'(data_two);
      end else if (hit(wb_adr_i, OFS_READY_DRIVE)) begin
         rd_word[READY_DRIVE_BIT] = ready_drive_r;
      end else if (hit(wb_adr_i, OFS_VALID_OBS)) begin
         rd_word[VALID_OBS_BIT] = port_one_valid_in_i | port_two_valid_in_i;
      end else if (hit(wb_adr_i, OFS_MODE_CTRL)) begin
         rd_word[MODE_W-1:0] = mode_r;
      end else if (hit(wb_adr_i, OFS_CAP_ID)) begin
         rd_word = CAP_VALUE;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence rd_at_s(logic [ADR_W-1:0] ofs);
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit(wb_adr_i, ofs);
   endsequence

   sequence ack_next_s;
      ##1 wb_ack_o ##1 !wb_ack_o;
   endsequence

   ack_once_a: assert property (req |-> ack_next_s)
      else $error("ack not a single pulse after request");

   sw_valid_bit_a: assert property (rd_at_s(OFS_INSTR_DATA) |=>
      wb_dat_o[SW_VALID_BIT] == $past(port_two_valid_in_i))
      else $error("software valid bit wrong");

   sw_count_read_a: assert property (rd_at_s(OFS_SW_DATA) |=>
      wb_dat_o[SW_CNT_LSB +: CNT_W] == $past(cnt_two) && cnt_two == CNT_W'($past(acc_two)))
      else $error("software count not reported or not cleared");

   instr_valid_bit_a: assert property (rd_at_s(OFS_SW_DATA) |=>
      wb_dat_o[INSTR_VALID_BIT] == $past(port_one_valid_in_i))
      else $error("instruction valid bit wrong");

   instr_drain_a: assert property (rd_at_s(OFS_INSTR_DATA) |=>
      wb_dat_o[23:0] == $past(data_one) && cnt_one == CNT_W'($past(acc_one)))
      else $error("instruction bytes not shown or not discarded");

   ready_drive_a: assert property (mode_r == MODE_INTEG |=>
      port_one_ready_out_o == $past(ready_drive_r) && port_two_ready_out_o == $past(ready_drive_r))
      else $error("ready outputs not driven by ready drive bit");

   valid_or_a: assert property (rd_at_s(OFS_VALID_OBS) |=>
      wb_dat_o == {31'h0, $past(port_one_valid_in_i | port_two_valid_in_i)})
      else $error("valid observe read wrong");

   mode_write_a: assert property (wr_take && wb_sel_i[0] && hit(wb_adr_i, OFS_MODE_CTRL) |=>
      mode_r == $past(wb_dat_i[MODE_W-1:0]))
      else $error("mode field not written");

   out_disable_a: assert property (mode_r == MODE_DATA |=> !trace_out_en_o)
      else $error("trace output enabled in data test mode");

   cap_value_a: assert property (rd_at_s(OFS_CAP_ID) |=> wb_dat_o[11:6] == 6'h32
      && wb_dat_o[4:0] == 5'h01 && wb_dat_o[31:12] == '0)
      else $error("capability word wrong");

   reserved_zero_a: assert property (rd_at_s(OFS_INSTR_DATA) |=> wb_dat_o[31:30] == 2'h0)
      else $error("reserved data bits not zero");

endmodule : tpi_integ_top
`default_nettype wire

// File: tpi_trace_src.sv
// Behavioural trace source that feeds one trace bus input port
`timescale 1ns/10ps
`default_nettype none
module tpi_trace_src (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ready_i,
   input wire logic slow_i,
   output logic valid_o,
   output logic [7:0] data_o
);
   logic [7:0] q[$];
   logic v_r = 1'b0;
   logic [7:0] d_r = 8'h00;

   // ----------------------------------------------------------------------
   // Bench entry point
   // ----------------------------------------------------------------------
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask : push

   // An offer is held until ready; idle data inverts on every idle cycle, so the first
   // idle cycle shows the inverse of the last byte and a sample one cycle late cannot match by luck
   always @(posedge clk_i) begin
      if (rst_i) begin
         v_r <= 1'b0;
      end else begin
         if (v_r && ready_i) begin
            void'(q.pop_front());
         end
         if (v_r && !ready_i) begin
            v_r <= 1'b1;
         end else if (q.size() > 0 && !(slow_i && $urandom_range(1, 0) == 1)) begin
            v_r <= 1'b1;
            d_r <= q[0];
         end else begin
            v_r <= 1'b0;
            d_r <= ~d_r;
         end
      end
   end

   assign valid_o = v_r;
   assign data_o = d_r;
endmodule : tpi_trace_src
`default_nettype wire

// File: tb_trace_port_integration_test.sv
// Self-checking bench for the trace port integration-test registers
`timescale 1ns/10ps
`default_nettype none
module tb_trace_port_integration_test;
   import tpi_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [ADR_W-1:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
   logic wb_ack, v1, v2, r1, r2, toe;
   logic func_rdy = 1'b0, slow = 1'b0;
   logic [7:0] d1, d2;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] pend[2][$];
   logic [7:0] store[2][$];

   // ----------------------------------------------------------------------
   // Clock, design and partner sources
   // ----------------------------------------------------------------------
   always #25 clk_i = ~clk_i;

   tpi_integ_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .port_one_valid_in_i(v1),
      .port_one_data_i(d1), .port_one_ready_out_o(r1), .port_two_valid_in_i(v2),
      .port_two_data_i(d2), .port_two_ready_out_o(r2), .func_ready_i(func_rdy),
      .trace_out_en_o(toe));
   tpi_trace_src src1 (.clk_i(clk_i), .rst_i(rst_i), .ready_i(r1), .slow_i(slow),
      .valid_o(v1), .data_o(d1));
   tpi_trace_src src2 (.clk_i(clk_i), .rst_i(rst_i), .ready_i(r2), .slow_i(slow),
      .valid_o(v2), .data_o(d2));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Classic cycle: held until ack is sampled, then released for a cycle
   task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= dat;
      wb_sel <= sel;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   task automatic rdchk(input logic [ADR_W-1:0] adr, input logic [31:0] exp, input string nm);
      wb(1'b0, adr, 32'h0, 4'hf);
      check(nm, rd, exp);
   endtask : rdchk

   task automatic push(input int p, input int n);
      logic [7:0] b;
      repeat (n) begin
         b = 8'($urandom);
         pend[p].push_back(b);
         if (p == 1) src2.push(b);
         else src1.push(b);
      end
   endtask : push

   // Model moves pending bytes into the store, then waits for the sources to agree
   task automatic settle_wait();
      int n;
      for (int p = 0; p < 2; p++) begin
         while (pend[p].size() > 0 && store[p].size() < CAP_DEPTH) begin
            store[p].push_back(pend[p].pop_front());
         end
      end
      n = 0;
      // Looked at mid-cycle, once the sources' pops and valid updates have settled
      @(negedge clk_i);
      while (n < 300 && !(src1.q.size() == pend[0].size() && src2.q.size() == pend[1].size()
             && v1 === (pend[0].size() > 0) && v2 === (pend[1].size() > 0))) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 300) begin
         fail_count++;
      end
      repeat (2) @(posedge clk_i);
   endtask : settle_wait

   task automatic rd_data(input int p);
      logic [31:0] e;
      e = 32'h0;
      e[29] = pend[1].size() > 0;
      e[28:27] = 2'(store[1].size());
      e[26] = pend[0].size() > 0;
      e[25:24] = 2'(store[0].size());
      for (int i = 0; i < store[p].size(); i++) e[i*8 +: 8] = store[p][i];
      wb(1'b0, (p == 1) ? OFS_SW_DATA : OFS_INSTR_DATA, 32'h0, 4'hf);
      check("data_reg", rd, e);
      store[p].delete();
      settle_wait();
   endtask : rd_data

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [31:0] x;
      void'($urandom(32'h16bc));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, read-only and unmapped places
      rdchk(OFS_MODE_CTRL, 32'h0, "mode_rst");
      rdchk(OFS_READY_DRIVE, 32'h0, "ready_drive_rst");
      rdchk(OFS_VALID_OBS, 32'h0, "valid_obs_idle");
      wb(1'b1, OFS_CAP_ID, 32'hffff_ffff, 4'hf);
      rdchk(OFS_CAP_ID, 32'h800 | 32'h400 | (32'h2 << 6) | 32'h1, "cap_id");
      rdchk(12'h004, 32'h0, "unmapped");
      // Every mode code, with a write that has sel[0] low and must be ignored
      for (int m = 0; m < 4; m++) begin
         func_rdy <= 1'($urandom_range(1, 0));
         x = $urandom;
         wb(1'b1, OFS_MODE_CTRL, {x[31:2], 2'(m)}, 4'hf);
         wb(1'b1, OFS_MODE_CTRL, {x[31:2], ~2'(m)}, 4'he);
         rdchk(OFS_MODE_CTRL, 32'(m), "mode");
         repeat (2) @(posedge clk_i);
         check("trace_out_en", toe, 32'(m != 2));
         check("ready", {r1, r2}, (m == 1) ? 2'b00 : (m == 2) ? 2'b11 : {2{func_rdy}});
      end
      // Integration test mode: valid OR table and driven ready
      wb(1'b1, OFS_MODE_CTRL, 32'h1, 4'hf);
      for (int k = 0; k < 4; k++) begin
         x = $urandom;
         wb(1'b1, OFS_READY_DRIVE, {x[31:1], 1'b0}, 4'hf);
         if (k[0]) src1.push(8'($urandom));
         if (k[1]) src2.push(8'($urandom));
         repeat (3) @(posedge clk_i);
         check("ready_low", {r1, r2}, 2'b00);
         rdchk(OFS_VALID_OBS, 32'(k != 0), "valid_or");
         wb(1'b1, OFS_READY_DRIVE, {x[31:1], 1'b1}, 4'hf);
         rdchk(OFS_READY_DRIVE, 32'h1, "ready_drive");
         check("ready_high", {r1, r2}, 2'b11);
         repeat (4) @(posedge clk_i);
      end
      // Data test mode: captures, full stores, stalling sources
      wb(1'b1, OFS_MODE_CTRL, 32'h2, 4'hf);
      for (int k = 0; k < 6; k++) begin
         slow <= (k > 2);
         push(0, $urandom_range(5, 0));
         push(1, $urandom_range(5, 0));
         settle_wait();
         rd_data(k % 2);
         rd_data(1 - k % 2);
      end
      while (pend[0].size() + pend[1].size() + store[0].size() + store[1].size() > 0) begin
         rd_data(0);
         rd_data(1);
      end
      wrap_up();
   end

   // Watchdog, far beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      wrap_up();
   end
endmodule : tb_trace_port_integration_test
`default_nettype wire
